// ### design/msmr_regs.v
/*
 * Motor status monitor register bank: selector, latched three-byte
 * status word, base address register and download/checksum command.
 * Assumes a serial-frame decoder on clk_i presenting one-cycle read
 * and write strobes with a 16-bit address, and an outside nonvolatile
 * engine that performs the copy or checksum when started.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msmr_defines.vh"

// Functional notes
// [RULE1] Selector 3h shows 22-bit latched input period count, top two bits zero.
// [RULE2] Selector 4h shows 22-bit latched input high count; duty is high/period*1024.
// [RULE3] Selector 5h shows 15-bit control target, 7FFFh max, 0000h zero.
// [RULE4] Selector 6h shows 10-bit PI duty result, 000h zero, 3FFh full.
// [RULE5] Selector 7h shows energizing position 00h..BFh, 1.875 degrees per step.
// [RULE6] Selector 8h: bit3 all phases connected, bits 2..0 W,V,U, zero when open.
// [RULE7] Selector 9h shows 8-bit configuration CRC remainder.
// [RULE8] Selector Ah shows 10-bit maximum output duty capping all phases.
// [RULE9] Selector Bh shows 5-bit actual lead angle from output duty.
// [RULE10] Selector Ch shows 5-bit target lead angle from duty and settings.
// [RULE11] Selector Dh bit 2 high while window count change is enabled.
// [RULE12] Selector Dh bit 1 high while zero-cross detection is enabled.
// [RULE13] Selector Dh bit 0 high while outputs are in high-impedance window.
// [RULE14] Selector Eh shows 15-bit output monitor target.
// [RULE15] Selector Eh: middle byte bit 7 is one for closed loop.
// [RULE16] 16-bit base address in two bytes, used when frame base select is Fh.
// [RULE17] Writing 00h to the command register starts the download.
// [RULE18] Writing FFh starts checksum; other values do nothing.
// [RULE19] Command writes ignored while the nonvolatile busy flag is high.
// [RULE20] Reading the low byte latches the upper two bytes until next low read.
// [RULE21] Status bytes at 0205h..0207h, selector at 0306h.
// [RULE22] Download copies nonvolatile 1000h..1022h into main bank 0000h..0401h.
// [RULE23] Bits with no field for the current selector read zero.
// [RULE24] Busy flag high for the whole download or checksum, cleared after.

module msmr_regs (
    input  wire        clk_i,
    input  wire        reset_i,
    // Register access from the serial frame decoder
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    input  wire [15:0] reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire [3:0]  base_select_field_i,
    input  wire [15:0] frame_addr_i,
    output wire [15:0] effective_addr_o,
    // Internal quantities
    input  wire [21:0] input_period_count_i,
    input  wire [21:0] input_high_count_i,
    input  wire [14:0] control_target_i,
    input  wire [9:0]  pi_duty_result_i,
    input  wire [7:0]  energizing_position_i,
    input  wire [2:0]  phase_connected_i,
    input  wire [7:0]  config_crc_remainder_i,
    input  wire [9:0]  max_output_duty_i,
    input  wire [4:0]  actual_lead_angle_i,
    input  wire [4:0]  target_lead_angle_i,
    input  wire        window_change_active_i,
    input  wire        zero_cross_detect_active_i,
    input  wire        high_impedance_window_i,
    input  wire [14:0] monitor_target_i,
    input  wire        closed_loop_flag_i,
    output wire [9:0]  input_duty_value_o,
    // Nonvolatile engine handshake
    input  wire        nvm_done_i,
    output reg         download_start_o,
    output reg         checksum_start_o,
    output wire [15:0] copy_src_first_o,
    output wire [15:0] copy_src_last_o,
    output wire [15:0] copy_dst_first_o,
    output wire [15:0] copy_dst_last_o,
    output reg         nvm_busy_flag_o
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg  [3:0]  status_selector;
    reg  [7:0]  base_address_low;
    reg  [7:0]  base_address_high;
    reg  [15:0] status_upper_latch;
    wire [23:0] status_word;
    wire [15:0] base_address_value;
    wire [31:0] duty_product;
    wire [31:0] duty_quotient;

    function automatic is_addr;
        input [15:0] a;
        input [15:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    msmr_status_mux u_mux (
        .status_selector_i          (status_selector),
        .input_period_count_i       (input_period_count_i),
        .input_high_count_i         (input_high_count_i),
        .control_target_i           (control_target_i),
        .pi_duty_result_i           (pi_duty_result_i),
        .energizing_position_i      (energizing_position_i),
        .phase_connected_i          (phase_connected_i),
        .config_crc_remainder_i     (config_crc_remainder_i),
        .max_output_duty_i          (max_output_duty_i),
        .actual_lead_angle_i        (actual_lead_angle_i),
        .target_lead_angle_i        (target_lead_angle_i),
        .window_change_active_i     (window_change_active_i),
        .zero_cross_detect_active_i (zero_cross_detect_active_i),
        .high_impedance_window_i    (high_impedance_window_i),
        .monitor_target_i           (monitor_target_i),
        .closed_loop_flag_i         (closed_loop_flag_i),
        .status_word_o              (status_word)
    );

    // ------------------------------------------------------------------
    // Input duty
    // ------------------------------------------------------------------
    // [RULE2] duty from counts; saturates at full scale, zero period gives zero
    assign duty_product  = {input_high_count_i, 10'h000};
    // Quotient stays below 1024 whenever high is below period
    assign duty_quotient = duty_product / {10'h000, input_period_count_i};
    assign input_duty_value_o =
        (input_period_count_i == 22'h000000) ? 10'h000 :
        (input_high_count_i >= input_period_count_i) ? 10'h3FF :
        duty_quotient[9:0];

    // ------------------------------------------------------------------
    // Base address
    // ------------------------------------------------------------------
    assign base_address_value = {base_address_high, base_address_low};
    // [RULE16] short-format address substitution
    assign effective_addr_o = (base_select_field_i == `MSMR_BASE_SELECT_USE) ?
                              base_address_value : frame_addr_i;

    // [RULE22] fixed copy ranges for the engine
    assign copy_src_first_o = `MSMR_NVM_FIRST;
    assign copy_src_last_o  = `MSMR_NVM_LAST;
    assign copy_dst_first_o = `MSMR_MAIN_FIRST;
    assign copy_dst_last_o  = `MSMR_MAIN_LAST;

    // ------------------------------------------------------------------
    // Register writes and command
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            status_selector   <= `MSMR_RST_SELECTOR;
            base_address_low  <= `MSMR_RST_BYTE;
            base_address_high <= `MSMR_RST_BYTE;
            download_start_o  <= 1'b0;
            checksum_start_o  <= 1'b0;
            nvm_busy_flag_o   <= 1'b0;
        end else begin
            download_start_o <= 1'b0;
            checksum_start_o <= 1'b0;
            // [RULE24] busy clears on completion
            if (nvm_done_i) begin
                nvm_busy_flag_o <= 1'b0;
            end
            if (reg_write_i) begin
                // [RULE21] selector location
                if (is_addr(reg_addr_i, `MSMR_ADDR_SELECTOR)) begin
                    status_selector <= reg_wdata_i[3:0];
                end
                // [RULE16] base address bytes
                if (is_addr(reg_addr_i, `MSMR_ADDR_BASE_LOW)) begin
                    base_address_low <= reg_wdata_i;
                end
                if (is_addr(reg_addr_i, `MSMR_ADDR_BASE_HIGH)) begin
                    base_address_high <= reg_wdata_i;
                end
                // [RULE19] command blocked while busy
                if (is_addr(reg_addr_i, `MSMR_ADDR_COMMAND) && !nvm_busy_flag_o) begin
                    // [RULE17] download start
                    if (reg_wdata_i == `MSMR_CMD_DOWNLOAD) begin
                        download_start_o <= 1'b1;
                        // [RULE24] busy raised with start
                        nvm_busy_flag_o  <= 1'b1;
                    end
                    // [RULE18] checksum start, others ignored
                    if (reg_wdata_i == `MSMR_CMD_CHECKSUM) begin
                        checksum_start_o <= 1'b1;
                        nvm_busy_flag_o  <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Status latch and read data
    // ------------------------------------------------------------------
    // Latch keeps the three bytes coherent across a sequential read
    always @(posedge clk_i) begin
        if (reset_i) begin
            status_upper_latch <= 16'h0000;
        end else if (reg_read_i && is_addr(reg_addr_i, `MSMR_ADDR_STAT_LOW)) begin
            // [RULE20] upper bytes latched on low read
            status_upper_latch <= status_word[23:8];
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= `MSMR_RST_BYTE;
        end else if (reg_read_i) begin
            // [RULE21] status byte locations
            case (reg_addr_i)
                `MSMR_ADDR_STAT_LOW:  reg_rdata_o <= status_word[7:0];
                `MSMR_ADDR_STAT_MID:  reg_rdata_o <= status_upper_latch[7:0];
                `MSMR_ADDR_STAT_HIGH: reg_rdata_o <= status_upper_latch[15:8];
                `MSMR_ADDR_SELECTOR:  reg_rdata_o <= {4'h0, status_selector};
                `MSMR_ADDR_BASE_LOW:  reg_rdata_o <= base_address_low;
                `MSMR_ADDR_BASE_HIGH: reg_rdata_o <= base_address_high;
                default:              reg_rdata_o <= `MSMR_RST_BYTE;
            endcase
        end
    end

endmodule // msmr_regs

`default_nettype wire

// ### common/msmr_defines.vh
/*
 * Constants for the motor status monitor register bank: byte addresses,
 * selector codes, command codes, copy ranges, limits and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MSMR_DEFINES_VH
`define MSMR_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MSMR_ADDR_STAT_LOW      16'h0205
`define MSMR_ADDR_STAT_MID      16'h0206
`define MSMR_ADDR_STAT_HIGH     16'h0207
`define MSMR_ADDR_SELECTOR      16'h0306
`define MSMR_ADDR_BASE_LOW      16'h0307
`define MSMR_ADDR_BASE_HIGH     16'h0308
`define MSMR_ADDR_COMMAND       16'h0400

// ----------------------------------------------------------------------
// Copy ranges
// ----------------------------------------------------------------------
`define MSMR_NVM_FIRST          16'h1000
`define MSMR_NVM_LAST           16'h1022
`define MSMR_MAIN_FIRST         16'h0000
`define MSMR_MAIN_LAST          16'h0401

// ----------------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------------
`define MSMR_SEL_PERIOD         4'h3
`define MSMR_SEL_HIGH           4'h4
`define MSMR_SEL_CTRL_TARGET    4'h5
`define MSMR_SEL_PI_DUTY        4'h6
`define MSMR_SEL_ENERGIZE       4'h7
`define MSMR_SEL_PHASE_OPEN     4'h8
`define MSMR_SEL_CRC            4'h9
`define MSMR_SEL_MAX_DUTY       4'hA
`define MSMR_SEL_ACT_LEAD       4'hB
`define MSMR_SEL_TGT_LEAD       4'hC
`define MSMR_SEL_LOOP_STATE     4'hD
`define MSMR_SEL_MON_TARGET     4'hE

// ----------------------------------------------------------------------
// Commands, base select, limits and resets
// ----------------------------------------------------------------------
`define MSMR_CMD_DOWNLOAD       8'h00
`define MSMR_CMD_CHECKSUM       8'hFF
`define MSMR_BASE_SELECT_USE    4'hF
`define MSMR_EPOS_MAX           8'hBF
`define MSMR_DUTY_SCALE_LOG2    10
`define MSMR_RST_BYTE           8'h00
`define MSMR_RST_SELECTOR       4'h0
`define MSMR_RST_WORD           24'h000000

`endif

// ### design/msmr_status_mux.v
/*
 * Status word multiplexer: selects one internal quantity into a 24-bit
 * word by the 4-bit selector, with unused bits at zero.
 * Assumes all inputs are on clk_i in the enclosing block.
 */
`timescale 1ns/1ps
`default_nettype none

module msmr_status_mux (
    input  wire [3:0]  status_selector_i,
    input  wire [21:0] input_period_count_i,
    input  wire [21:0] input_high_count_i,
    input  wire [14:0] control_target_i,
    input  wire [9:0]  pi_duty_result_i,
    input  wire [7:0]  energizing_position_i,
    input  wire [2:0]  phase_connected_i,
    input  wire [7:0]  config_crc_remainder_i,
    input  wire [9:0]  max_output_duty_i,
    input  wire [4:0]  actual_lead_angle_i,
    input  wire [4:0]  target_lead_angle_i,
    input  wire        window_change_active_i,
    input  wire        zero_cross_detect_active_i,
    input  wire        high_impedance_window_i,
    input  wire [14:0] monitor_target_i,
    input  wire        closed_loop_flag_i,
    output reg  [23:0] status_word_o
);

    wire [7:0] epos_clamped;

    // Clamp guards against a stray value past the last position
    // [RULE5] position limit
    assign epos_clamped = (energizing_position_i > `MSMR_EPOS_MAX) ?
                          `MSMR_EPOS_MAX : energizing_position_i;

    // [RULE23] unassigned bits zero
    always @* begin
        status_word_o = `MSMR_RST_WORD;
        case (status_selector_i)
            // [RULE1] period count
            `MSMR_SEL_PERIOD:      status_word_o = {2'h0, input_period_count_i};
            // [RULE2] high count
            `MSMR_SEL_HIGH:        status_word_o = {2'h0, input_high_count_i};
            // [RULE3] control target
            `MSMR_SEL_CTRL_TARGET: status_word_o = {9'h000, control_target_i};
            // [RULE4] PI duty
            `MSMR_SEL_PI_DUTY:     status_word_o = {14'h0000, pi_duty_result_i};
            `MSMR_SEL_ENERGIZE:    status_word_o = {16'h0000, epos_clamped};
            // [RULE6] phase open flags
            `MSMR_SEL_PHASE_OPEN:  status_word_o = {20'h00000, &phase_connected_i,
                                                    phase_connected_i};
            // [RULE7] CRC remainder
            `MSMR_SEL_CRC:         status_word_o = {16'h0000, config_crc_remainder_i};
            // [RULE8] maximum duty
            `MSMR_SEL_MAX_DUTY:    status_word_o = {14'h0000, max_output_duty_i};
            // [RULE9] actual lead
            `MSMR_SEL_ACT_LEAD:    status_word_o = {19'h00000, actual_lead_angle_i};
            // [RULE10] target lead
            `MSMR_SEL_TGT_LEAD:    status_word_o = {19'h00000, target_lead_angle_i};
            // [RULE11] [RULE12] [RULE13] loop state bits
            `MSMR_SEL_LOOP_STATE:  status_word_o = {21'h00000, window_change_active_i,
                                                    zero_cross_detect_active_i,
                                                    high_impedance_window_i};
            // [RULE14] [RULE15] monitor target and loop flag
            `MSMR_SEL_MON_TARGET:  status_word_o = {8'h00, closed_loop_flag_i,
                                                    monitor_target_i};
            default:               status_word_o = `MSMR_RST_WORD;
        endcase
    end

endmodule // msmr_status_mux

`default_nettype wire

// ### dv/msmr_regs_asserts.sv
/* Port checker for msmr_regs.
   Assumes a bind by port name onto every msmr_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module msmr_regs_asserts (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [3:0]  base_select_field_i,
    input wire logic [15:0] frame_addr_i,
    input wire logic [15:0] effective_addr_o,
    input wire logic [21:0] input_period_count_i,
    input wire logic [9:0]  input_duty_value_o,
    input wire logic        nvm_done_i,
    input wire logic        download_start_o,
    input wire logic        checksum_start_o,
    input wire logic        nvm_busy_flag_o
);
// ----
// Command and status relations
// ----
default clocking @(posedge clk_i); endclocking
default disable iff (reset_i);
logic cmd_wr;
assign cmd_wr = reg_write_i && reg_addr_i == 16'h0400;
dl_start_a: assert property (cmd_wr && !nvm_busy_flag_o && reg_wdata_i == 8'h00
    |=> download_start_o && !checksum_start_o && nvm_busy_flag_o) else $error("no download");
ck_start_a: assert property (cmd_wr && !nvm_busy_flag_o && reg_wdata_i == 8'hFF
    |=> checksum_start_o && !download_start_o && nvm_busy_flag_o) else $error("no checksum");
cmd_other_a: assert property (cmd_wr && !nvm_busy_flag_o && reg_wdata_i != 8'h00
    && reg_wdata_i != 8'hFF |=> !download_start_o && !checksum_start_o && !nvm_busy_flag_o)
    else $error("bad command acted on");
cmd_blocked_a: assert property (cmd_wr && nvm_busy_flag_o
    |=> !download_start_o && !checksum_start_o) else $error("command taken while busy");
busy_hold_a: assert property (nvm_busy_flag_o && !nvm_done_i |=> nvm_busy_flag_o)
    else $error("busy dropped early");
busy_clear_a: assert property (nvm_busy_flag_o && nvm_done_i |=> !nvm_busy_flag_o)
    else $error("busy stuck");
start_pulse_a: assert property (download_start_o || checksum_start_o
    |=> !(download_start_o || checksum_start_o) [*2]) else $error("start too long");
base_pass_a: assert property (base_select_field_i != 4'hF
    |-> effective_addr_o == frame_addr_i) else $error("frame address not passed");
unmapped_rd_a: assert property (reg_read_i && (reg_addr_i == 16'h0100
    || reg_addr_i == 16'h0400) |=> reg_rdata_o == 8'h00) else $error("unmapped read");
duty_zero_a: assert property (input_period_count_i == 22'h000000
    |-> input_duty_value_o == 10'h000) else $error("duty with zero period");
cover property (download_start_o);
cover property (checksum_start_o);
cover property (cmd_wr && nvm_busy_flag_o);
endmodule // msmr_regs_asserts
bind msmr_regs msmr_regs_asserts chk (.*);
`default_nettype wire

// ### dv/msmr_nvm_model.sv
/* Stand-in for the nonvolatile engine: a done pulse per start.
   Assumes one-cycle start pulses and delay_i of at least 1. */
`timescale 1ns/1ps
`default_nettype none
module msmr_nvm_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       start_i,
    input  wire logic [7:0] delay_i,
    output var  logic       done_o
);
// ----
// Timed copy or checksum
// ----
logic [7:0] count;
always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (reset_i) begin
        count <= 8'h00;
    end else if (start_i) begin
        count <= delay_i;
    end else if (count != 8'h00) begin
        count <= count - 8'h01;
        done_o <= (count == 8'h01);
    end
end
endmodule // msmr_nvm_model
`default_nettype wire

// ### dv/motor_status_monitor_regs_tb.sv
/* Self-checking bench for msmr_regs with the engine model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module motor_status_monitor_regs_tb;
logic        clk_i, reset_i, reg_write_i, reg_read_i, nvm_done_i, closed_loop_flag_i;
logic        window_change_active_i, zero_cross_detect_active_i, high_impedance_window_i;
logic        download_start_o, checksum_start_o, nvm_busy_flag_o;
logic [15:0] reg_addr_i, frame_addr_i, effective_addr_o, copy_src_first_o, copy_src_last_o;
logic [15:0] copy_dst_first_o, copy_dst_last_o;
logic [21:0] input_period_count_i, input_high_count_i;
logic [14:0] control_target_i, monitor_target_i;
logic [9:0]  pi_duty_result_i, max_output_duty_i, input_duty_value_o;
logic [7:0]  reg_wdata_i, reg_rdata_o, energizing_position_i, config_crc_remainder_i, delay;
logic [4:0]  actual_lead_angle_i, target_lead_angle_i;
logic [3:0]  base_select_field_i;
logic [2:0]  phase_connected_i;
logic [23:0] word;
int          errors, samples_checked, dl_n, ck_n;
msmr_regs uut (.*);
msmr_nvm_model nvm (.clk_i(clk_i), .reset_i(reset_i), .start_i(download_start_o |
    checksum_start_o), .delay_i(delay), .done_o(nvm_done_i));
// ----
// Bus tasks, all entered at a falling edge
// ----
task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
        errors++;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_write_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_write_i = 1'b0;
    @(negedge clk_i);
endtask
task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_read_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_read_i = 1'b0;
    d = reg_rdata_o;
    @(negedge clk_i);
endtask
task automatic rd_word();
    rd(16'h0205, word[7:0]);
    rd(16'h0206, word[15:8]);
    rd(16'h0207, word[23:16]);
endtask
task automatic load(input logic b);
    input_period_count_i = b ? 22'h15A3C1 : 22'h2A5C3E;
    input_high_count_i = b ? 22'h2A5C3E : 22'h15A3C1;
    control_target_i = b ? 15'h0000 : 15'h7FFF;
    pi_duty_result_i = b ? 10'h000 : 10'h3FF;
    energizing_position_i = b ? 8'hC4 : 8'hBF;
    phase_connected_i = b ? 3'b101 : 3'b111;
    config_crc_remainder_i = b ? 8'h5A : 8'hA5;
    max_output_duty_i = b ? 10'h13C : 10'h2C3;
    actual_lead_angle_i = b ? 5'h00 : 5'h1F;
    target_lead_angle_i = b ? 5'h15 : 5'h0A;
    {window_change_active_i, zero_cross_detect_active_i, high_impedance_window_i} = {~b, b, ~b};
    monitor_target_i = b ? 15'h7FFF : 15'h2B4D;
    closed_loop_flag_i = b;
endtask
function automatic logic [23:0] expw(input logic [3:0] s);
    case (s)
        4'h3: return {2'h0, input_period_count_i};
        4'h4: return {2'h0, input_high_count_i};
        4'h5: return {9'h000, control_target_i};
        4'h6: return {14'h0000, pi_duty_result_i};
        4'h7: return {16'h0000, (energizing_position_i > 8'hBF) ? 8'hBF : energizing_position_i};
        4'h8: return {20'h00000, &phase_connected_i, phase_connected_i};
        4'h9: return {16'h0000, config_crc_remainder_i};
        4'hA: return {14'h0000, max_output_duty_i};
        4'hB: return {19'h00000, actual_lead_angle_i};
        4'hC: return {19'h00000, target_lead_angle_i};
        4'hD: return {21'h00000, window_change_active_i, zero_cross_detect_active_i,
            high_impedance_window_i};
        4'hE: return {8'h00, closed_loop_flag_i, monitor_target_i};
        default: return 24'h000000;
    endcase
endfunction
// ----
// Scenarios
// ----
task automatic t_reset();
    logic [15:0] ra [7] = '{16'h0307, 16'h0308, 16'h0206, 16'h0207, 16'h0306, 16'h0400, 16'h0100};
    for (int i = 0; i < 7; i++) begin
        rd(ra[i], word[7:0]);
        chk(word[7:0], 24'h0);
    end
endtask
task automatic t_select(input logic b);
    load(b);
    for (int s = 0; s < 16; s++) begin
        wr(16'h0306, 8'(s));
        rd(16'h0306, word[7:0]);
        chk(word[7:0], 24'(s));
        rd_word();
        chk(word, expw(4'(s)));
    end
endtask
task automatic t_latch();
    load(1'b0);
    wr(16'h0306, 8'h03);
    rd(16'h0205, word[7:0]);
    wr(16'h0306, 8'h04);
    input_period_count_i = 22'h3FFFFF;
    rd(16'h0206, word[15:8]);
    rd(16'h0207, word[23:16]);
    chk(word[23:8], {2'h0, 22'h2A5C3E} >> 8);
    rd_word();
    chk(word, {2'h0, input_high_count_i});
endtask
task automatic t_duty();
    {input_period_count_i, input_high_count_i} = {22'h000400, 22'h000100};
    #1 chk(input_duty_value_o, 24'h100);
    input_high_count_i = 22'h000400;
    #1 chk(input_duty_value_o, 24'h3FF);
    input_period_count_i = 22'h000000;
    #1 chk(input_duty_value_o, 24'h000);
    @(negedge clk_i);
endtask
task automatic t_base();
    wr(16'h0307, 8'h34);
    wr(16'h0308, 8'h12);
    {base_select_field_i, frame_addr_i} = {4'hF, 16'hABCD};
    rd(16'h0308, word[15:8]);
    rd(16'h0307, word[7:0]);
    chk(word[15:0], {8'h00, effective_addr_o});
    chk(effective_addr_o, 24'h1234);
    base_select_field_i = 4'h3;
    #1 chk(effective_addr_o, 24'hABCD);
    @(negedge clk_i);
endtask
task automatic wait_idle();
    for (int i = 0; i < 100 && nvm_busy_flag_o !== 1'b0; i++) @(negedge clk_i);
    chk(nvm_busy_flag_o, 24'h0);
endtask
task automatic t_cmd();
    delay = 8'd20;
    wr(16'h0400, 8'h00);
    chk(nvm_busy_flag_o, 24'h1);
    wr(16'h0400, 8'hFF);
    wait_idle();
    chk({dl_n[11:0], ck_n[11:0]}, 24'h001000);
    delay = 8'd1;
    wr(16'h0400, 8'hFF);
    wait_idle();
    wr(16'h0400, 8'h5A);
    chk({nvm_busy_flag_o, dl_n[10:0], ck_n[11:0]}, 24'h001001);
    chk({copy_src_last_o, copy_dst_last_o[7:0]}, 24'h102201);
    chk({copy_src_first_o, copy_dst_first_o[7:0]}, 24'h100000);
    chk({copy_dst_first_o, copy_dst_last_o[15:8]}, 24'h000004);
endtask
// ----
// Run control
// ----
task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
always @(posedge clk_i) begin
    dl_n += (download_start_o === 1'b1);
    ck_n += (checksum_start_o === 1'b1);
end
initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
end
initial begin
    #100000;
    errors++;
    tally_and_finish();
end
initial begin
    {reset_i, reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} = {1'b1, 26'h0};
    {base_select_field_i, frame_addr_i, delay} = {20'h0, 8'd4};
    load(1'b0);
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    t_reset();
    t_select(1'b0);
    t_select(1'b1);
    t_latch();
    t_duty();
    t_base();
    t_cmd();
    tally_and_finish();
end
endmodule // motor_status_monitor_regs_tb
`default_nettype wire
